// ### design/router_pkg.sv
package router_pkg;
    typedef logic [15:0] param_word_t;
    typedef logic [11:0] param_num_t;
    typedef logic signed [15:0] mon_word_t;
    typedef logic [3:0] field_t;

    // parameter numbers used on the parameter access port
    localparam param_num_t num_route_one = 12'h50e;
    localparam param_num_t num_route_two = 12'h50f;
    localparam param_num_t num_route_three = 12'h510;
    localparam param_num_t num_invert = 12'h512;
    localparam param_num_t num_monitor = 12'h003;

    // reset values
    localparam param_word_t rst_route_one = 16'h3211;
    localparam param_word_t rst_route_two = 16'h0000;
    localparam param_word_t rst_route_three = 16'h0000;
    localparam param_word_t rst_invert = 16'h0000;
    localparam param_word_t rst_monitor = 16'h0002;

    // field layout
    localparam int field_width = 4;
    localparam int status_count = 9;
    localparam int circuit_count = 3;
    localparam int invert_bits = 3;
    localparam int monitor_one_pos = 0;
    localparam int monitor_two_pos = 4;

    // status signal positions in the status vector
    localparam int sig_positioning_done_one = 0;
    localparam int sig_speed_match = 1;
    localparam int sig_rotation_detect = 2;
    localparam int sig_servo_ready = 3;
    localparam int sig_current_limit_hit = 4;
    localparam int sig_speed_limit_hit = 5;
    localparam int sig_brake_interlock = 6;
    localparam int sig_warning = 7;
    localparam int sig_positioning_done_two = 8;

    // selector codes
    localparam field_t route_off = 4'h0;

    // monitor source codes
    localparam field_t mon_motor_speed = 4'h0;
    localparam field_t mon_speed_cmd = 4'h1;
    localparam field_t mon_torque_cmd = 4'h2;
    localparam field_t mon_dev_fine = 4'h3;
    localparam field_t mon_dev_coarse = 4'h4;
    localparam field_t mon_pulse_rate = 4'h5;
    localparam field_t mon_speed_x4 = 4'h6;
    localparam field_t mon_speed_x8 = 4'h7;
endpackage

// ### design/monitor_if.sv
interface monitor_if;
    import router_pkg::*;
    field_t code_one;
    field_t code_two;
    mon_word_t motor_speed;
    mon_word_t speed_cmd;
    mon_word_t torque_cmd;
    mon_word_t position_dev;
    mon_word_t pulse_rate;
    mon_word_t value_one;
    mon_word_t value_two;
    logic defined_one;
    logic defined_two;

    modport ctl (
        output code_one, code_two, motor_speed, speed_cmd, torque_cmd,
        output position_dev, pulse_rate,
        input value_one, value_two, defined_one, defined_two
    );
    modport sel (
        input code_one, code_two, motor_speed, speed_cmd, torque_cmd,
        input position_dev, pulse_rate,
        output value_one, value_two, defined_one, defined_two
    );
endinterface

// ### design/monitor_source_select.sv
module monitor_source_select (
    // clock and control
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // monitor selection
    monitor_if.sel mon
);
    import router_pkg::*;

    mon_word_t next_value_one;
    mon_word_t next_value_two;
    logic next_defined_one;
    logic next_defined_two;
    mon_word_t value_one;
    mon_word_t value_two;
    logic defined_one;
    logic defined_two;

    // raw source word; the gain for each code is applied by the converter
    function automatic mon_word_t pick(input field_t code,
                                       input mon_word_t spd,
                                       input mon_word_t scmd,
                                       input mon_word_t tcmd,
                                       input mon_word_t dev,
                                       input mon_word_t rate);
        case (code)
            mon_motor_speed, mon_speed_x4, mon_speed_x8: pick = spd;
            mon_speed_cmd: pick = scmd;
            mon_torque_cmd: pick = tcmd;
            mon_dev_fine, mon_dev_coarse: pick = dev;
            mon_pulse_rate: pick = rate;
            default: pick = 16'sh0000;
        endcase
    endfunction

    function automatic logic is_defined(input field_t code);
        is_defined = (code <= mon_speed_x8);
    endfunction

    always_comb begin
        next_value_one = value_one;
        next_value_two = value_two;
        next_defined_one = defined_one;
        next_defined_two = defined_two;
        if (rst_in) begin
            next_value_one = 16'sh0000;
            next_value_two = 16'sh0000;
            next_defined_one = 1'b0;
            next_defined_two = 1'b0;
        end else if (ce_in) begin
            next_value_one = pick(mon.code_one, mon.motor_speed,
                mon.speed_cmd, mon.torque_cmd, mon.position_dev,
                mon.pulse_rate);
            next_value_two = pick(mon.code_two, mon.motor_speed,
                mon.speed_cmd, mon.torque_cmd, mon.position_dev,
                mon.pulse_rate);
            next_defined_one = is_defined(mon.code_one);
            next_defined_two = is_defined(mon.code_two);
        end
    end

    always_ff @(posedge clock_in) begin
        value_one <= next_value_one;
        value_two <= next_value_two;
        defined_one <= next_defined_one;
        defined_two <= next_defined_two;
    end

    assign mon.value_one = value_one;
    assign mon.value_two = value_two;
    assign mon.defined_one = defined_one;
    assign mon.defined_two = defined_two;

    a_reserved_code: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ce_in && mon.code_one > mon_speed_x8 |=> !defined_one &&
            value_one == 16'sh0000)
        else $error("reserved monitor code gave a defined output");

    a_torque_pick: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ce_in && mon.code_two == mon_torque_cmd |=>
            value_two == $past(mon.torque_cmd) && defined_two)
        else $error("monitor two did not carry the torque command");
endmodule

// ### design/servo_output_signal_router.sv
// Operation
// - selector 0 disables; 1, 2, 3 route to circuits one to three
// - fields map nine status signals across the three selection registers
// - signals sharing one circuit are combined by logical OR
// - a signal not currently detected contributes an inactive level
// - reset loads selection one with 3211, selections two and three with 0000
// - polarity bits 0..2 invert circuits, bit 3 reserved, reset 0000
// - monitor one in field 0 resets to 2, monitor two in field 1 to 0
// - codes 0,1,2,5,6,7 pick speed, commands, pulse rate, finer speed
// - codes 3 and 4 select position deviation; 8 to F are reserved
module servo_output_signal_router (
    // clock and control
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // parameter access
    input wire logic param_write_in,
    input wire logic param_read_in,
    input wire router_pkg::param_num_t param_number_in,
    input wire router_pkg::param_word_t param_data_in,
    output logic param_read_valid_out,
    output router_pkg::param_word_t param_read_data_out,
    output logic param_unknown_out,
    // status signals, high while detected
    input wire logic positioning_done_one_in,
    input wire logic speed_match_in,
    input wire logic rotation_detect_in,
    input wire logic servo_ready_in,
    input wire logic current_limit_hit_in,
    input wire logic speed_limit_hit_in,
    input wire logic brake_interlock_in,
    input wire logic warning_in,
    input wire logic positioning_done_two_in,
    // sequence output circuits
    output logic [2:0] circuit_out,
    // analog monitor sources
    input wire router_pkg::mon_word_t motor_speed_in,
    input wire router_pkg::mon_word_t speed_cmd_in,
    input wire router_pkg::mon_word_t torque_cmd_in,
    input wire router_pkg::mon_word_t position_dev_in,
    input wire router_pkg::mon_word_t pulse_rate_in,
    output router_pkg::mon_word_t monitor_one_out,
    output router_pkg::mon_word_t monitor_two_out,
    output logic monitor_one_defined_out,
    output logic monitor_two_defined_out
);
    import router_pkg::*;

    param_word_t route_one;
    param_word_t route_two;
    param_word_t route_three;
    logic [invert_bits-1:0] invert;
    param_word_t monitor_sel;
    param_word_t next_route_one;
    param_word_t next_route_two;
    param_word_t next_route_three;
    logic [invert_bits-1:0] next_invert;
    param_word_t next_monitor_sel;

    logic read_valid;
    param_word_t read_data;
    logic unknown;
    logic next_read_valid;
    param_word_t next_read_data;
    logic next_unknown;

    logic [status_count-1:0] status;
    logic [field_width*status_count-1:0] route_all;
    logic [circuit_count-1:0] combined;
    logic [circuit_count-1:0] circuit;
    logic [circuit_count-1:0] next_circuit;

    monitor_if mon ();

    // codes 4 to f are treated as disabled, like code 0
    function automatic logic routes_to(input field_t sel, input int k);
        routes_to = (sel != route_off) && (sel == field_t'(k + 1));
    endfunction

    function automatic logic known_number(input param_num_t num);
        known_number = num == num_route_one || num == num_route_two ||
            num == num_route_three || num == num_invert ||
            num == num_monitor;
    endfunction

    // parameter storage
    always_comb begin
        next_route_one = route_one;
        next_route_two = route_two;
        next_route_three = route_three;
        next_invert = invert;
        next_monitor_sel = monitor_sel;
        if (rst_in) begin
            next_route_one = rst_route_one;
            next_route_two = rst_route_two;
            next_route_three = rst_route_three;
            next_invert = rst_invert[invert_bits-1:0];
            next_monitor_sel = rst_monitor;
        end else if (ce_in && param_write_in) begin
            case (param_number_in)
                num_route_one: next_route_one = param_data_in;
                num_route_two: next_route_two = param_data_in;
                num_route_three: next_route_three = param_data_in;
                // reserved field 3 is not stored
                num_invert: next_invert = param_data_in[invert_bits-1:0];
                num_monitor: next_monitor_sel = param_data_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        route_one <= next_route_one;
        route_two <= next_route_two;
        route_three <= next_route_three;
        invert <= next_invert;
        monitor_sel <= next_monitor_sel;
    end

    // readback, one cycle after the read strobe
    always_comb begin
        next_read_valid = read_valid;
        next_read_data = read_data;
        next_unknown = unknown;
        if (rst_in) begin
            next_read_valid = 1'b0;
            next_read_data = 16'h0000;
            next_unknown = 1'b0;
        end else if (ce_in) begin
            next_read_valid = param_read_in;
            next_unknown = (param_read_in || param_write_in) &&
                !known_number(param_number_in);
            if (param_read_in) begin
                case (param_number_in)
                    num_route_one: next_read_data = route_one;
                    num_route_two: next_read_data = route_two;
                    num_route_three: next_read_data = route_three;
                    num_invert: next_read_data = {13'h0000, invert};
                    num_monitor: next_read_data = monitor_sel;
                    default: next_read_data = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in) begin
        read_valid <= next_read_valid;
        read_data <= next_read_data;
        unknown <= next_unknown;
    end

    // an undetected signal is low here and so adds nothing to the OR
    assign status = {positioning_done_two_in, warning_in, brake_interlock_in,
        speed_limit_hit_in, current_limit_hit_in, servo_ready_in,
        rotation_detect_in, speed_match_in, positioning_done_one_in};
    assign route_all = {route_three[field_width-1:0], route_two,
        route_one};

    always_comb begin
        combined = '0;
        for (int k = 0; k < circuit_count; k++) begin
            for (int i = 0; i < status_count; i++) begin
                if (routes_to(route_all[field_width*i +: field_width],
                        k)) begin
                    combined[k] = combined[k] | status[i];
                end
            end
        end
    end

    always_comb begin
        next_circuit = circuit;
        if (rst_in) begin
            next_circuit = '0;
        end else if (ce_in) begin
            next_circuit = combined ^ invert;
        end
    end

    always_ff @(posedge clock_in) begin
        circuit <= next_circuit;
    end

    assign mon.code_one = monitor_sel[monitor_one_pos +: field_width];
    assign mon.code_two = monitor_sel[monitor_two_pos +: field_width];
    assign mon.motor_speed = motor_speed_in;
    assign mon.speed_cmd = speed_cmd_in;
    assign mon.torque_cmd = torque_cmd_in;
    assign mon.position_dev = position_dev_in;
    assign mon.pulse_rate = pulse_rate_in;

    monitor_source_select u_monitor (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .mon(mon.sel)
    );

    assign circuit_out = circuit;
    assign param_read_valid_out = read_valid;
    assign param_read_data_out = read_data;
    assign param_unknown_out = unknown;
    assign monitor_one_out = mon.value_one;
    assign monitor_two_out = mon.value_two;
    assign monitor_one_defined_out = mon.defined_one;
    assign monitor_two_defined_out = mon.defined_two;

    sequence s_ready_to_first;
        ce_in && route_one[12 +: field_width] == 4'h1 && invert[0] == 1'b0 &&
            servo_ready_in;
    endsequence

    sequence s_all_off;
        ce_in && route_all == '0;
    endsequence

    a_reset_route: assert property (
        @(posedge clock_in) rst_in |=> route_one == 16'h3211 &&
            route_two == 16'h0000 && route_three == 16'h0000)
        else $error("selection registers wrong after reset");

    a_reset_monitor: assert property (
        @(posedge clock_in) rst_in |=> monitor_sel == 16'h0002 &&
            invert == 3'h0)
        else $error("monitor or polarity register wrong after reset");

    a_disabled_quiet: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_all_off ##0 invert == 3'h0 |=> circuit_out == 3'h0)
        else $error("circuit active with every signal disabled");

    a_or_combine: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_ready_to_first |=> circuit_out[0])
        else $error("routed signal missing from the OR");

    a_invert_idle: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_all_off |=> circuit_out == $past(invert))
        else $error("inversion not applied to the idle level");

    a_write_route: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ce_in && param_write_in && param_number_in == 12'h50f |=>
            route_two == $past(param_data_in))
        else $error("selection two not written");

    a_reserved_read: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ce_in && param_read_in && param_number_in == 12'h512 |=>
            param_read_valid_out && param_read_data_out[15:3] == 13'h0000)
        else $error("reserved polarity bits read nonzero");

    a_frozen_state: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !ce_in |=> $stable(circuit_out) && $stable(route_one))
        else $error("state moved while clock enable low");
endmodule

// ### testbench/host_seq_inputs.sv
// host sequence inputs wired to the three output circuits; the opto
// isolation is not modelled, so the host sees the raw level one cycle late
module host_seq_inputs (
    // clock
    input wire logic clock_in,
    // wired circuits
    input wire logic [2:0] circuit_in,
    // levels latched by the host
    output logic [2:0] seen_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock_in) begin
        seen_out <= circuit_in;
    end
endmodule

// ### testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import router_pkg::*;
    logic clock_in = 1'b0;
    logic rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    param_num_t num = 12'h000;
    param_word_t wdata = 16'h0000;
    logic rvalid, unk, d1, d2;
    param_word_t rdata;
    logic [8:0] st = 9'h000;
    logic [2:0] circ, seen, exp3;
    mon_word_t m1, m2;
    int n_fail = 0, n_tests = 0;
    param_word_t cfg_a[5] = '{16'h3211, 16'h3001, 16'h4f21, 16'h1123, 16'h0};
    param_word_t cfg_b[5] = '{16'h0000, 16'h0200, 16'h3210, 16'h2f31, 16'h0};
    param_word_t cfg_c[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0};
    param_word_t pol[5] = '{16'h0000, 16'h0000, 16'h0005, 16'hfffa, 16'h0};
    logic [8:0] pat[12] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020,
        9'h040, 9'h080, 9'h100, 9'h1ff, 9'h0a5, 9'h000};

    always #5 clock_in = ~clock_in;

    servo_output_signal_router dut_u (
        .clock_in(clock_in), .rst_in(rst), .ce_in(ce),
        .param_write_in(wr), .param_read_in(rd), .param_number_in(num),
        .param_data_in(wdata), .param_read_valid_out(rvalid),
        .param_read_data_out(rdata), .param_unknown_out(unk),
        .positioning_done_one_in(st[0]), .speed_match_in(st[1]),
        .rotation_detect_in(st[2]), .servo_ready_in(st[3]),
        .current_limit_hit_in(st[4]), .speed_limit_hit_in(st[5]),
        .brake_interlock_in(st[6]), .warning_in(st[7]),
        .positioning_done_two_in(st[8]), .circuit_out(circ),
        .motor_speed_in(16'h1111), .speed_cmd_in(16'h2222),
        .torque_cmd_in(16'h3333), .position_dev_in(16'h4444),
        .pulse_rate_in(16'h5555), .monitor_one_out(m1),
        .monitor_two_out(m2), .monitor_one_defined_out(d1),
        .monitor_two_defined_out(d2)
    );

    host_seq_inputs host_u (
        .clock_in(clock_in), .circuit_in(circ), .seen_out(seen)
    );

    function automatic logic [2:0] exp_circ(param_word_t a, param_word_t b,
            param_word_t c, param_word_t p, logic [8:0] s);
        logic [35:0] f;
        logic [3:0] v;
        logic [2:0] r;
        f = {c[3:0], b, a};
        r = 3'h0;
        for (int i = 0; i < 9; i++) begin
            v = f[4*i +: 4];
            if (v >= 4'h1 && v <= 4'h3) r[v - 4'h1] = r[v - 4'h1] | s[i];
        end
        return r ^ p[2:0];
    endfunction

    function automatic mon_word_t exp_mon(field_t c);
        case (c)
            4'h0, 4'h6, 4'h7: return 16'h1111;
            4'h1: return 16'h2222;
            4'h2: return 16'h3333;
            4'h3, 4'h4: return 16'h4444;
            4'h5: return 16'h5555;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (8) @(posedge clock_in);
        #1 rst = 1'b0;
    endtask

    task automatic wr_param(param_num_t n, param_word_t d);
        @(posedge clock_in);
        #1 wr = 1'b1;
        num = n;
        wdata = d;
        @(posedge clock_in);
        #1 wr = 1'b0;
    endtask

    task automatic rd_param(param_num_t n, param_word_t e, string nm);
        @(posedge clock_in);
        #1 rd = 1'b1;
        num = n;
        @(posedge clock_in);
        #1 rd = 1'b0;
        chk({nm, " valid"}, 16'h1, {15'h0, rvalid});
        chk(nm, e, rdata);
    endtask

    task automatic rd_all(param_word_t a, param_word_t b, param_word_t c,
            param_word_t p, param_word_t m);
        rd_param(num_route_one, a, "route one");
        rd_param(num_route_two, b, "route two");
        rd_param(num_route_three, c, "route three");
        rd_param(num_invert, p, "invert");
        rd_param(num_monitor, m, "monitor");
    endtask

    task automatic settle();
        repeat (3) @(posedge clock_in);
        #1;
    endtask

    initial begin
        do_reset();
        rd_all(16'h3211, 16'h0, 16'h0, 16'h0, 16'h2);
        $display("test reset values done");
        // entry one is the standard allocation; entry three has codes 4..f
        for (int k = 0; k < 5; k++) begin
            wr_param(num_route_one, cfg_a[k]);
            wr_param(num_route_two, cfg_b[k]);
            wr_param(num_route_three, cfg_c[k]);
            wr_param(num_invert, pol[k]);
            rd_all(cfg_a[k], cfg_b[k], cfg_c[k], pol[k] & 16'h7,
                16'h2);
            for (int j = 0; j < 12; j++) begin
                st = pat[j];
                exp3 = exp_circ(cfg_a[k], cfg_b[k], cfg_c[k], pol[k], pat[j]);
                settle();
                chk("circuit", 16'(exp3), 16'(circ));
                chk("host view", 16'(exp3), 16'(seen));
            end
        end
        $display("test routing done");
        for (int c = 0; c < 16; c++) begin
            wr_param(num_monitor, {8'h5a, 4'(15 - c), 4'(c)});
            settle();
            chk("monitor one", exp_mon(4'(c)), m1);
            chk("monitor two", exp_mon(4'(15 - c)), m2);
            chk("defined one", 16'(c < 8), 16'(d1));
            chk("defined two", 16'(c > 7), 16'(d2));
        end
        rd_param(num_monitor, 16'h5a0f, "monitor");
        $display("test monitors done");
        wr_param(12'h50d, 16'hffff);
        chk("unknown write", 16'h1, 16'(unk));
        @(posedge clock_in);
        #1 rd = 1'b1;
        num = 12'h511;
        @(posedge clock_in);
        #1 rd = 1'b0;
        chk("unknown read", 16'h1, 16'(unk));
        // a stray write must not land in any neighbouring register
        rd_all(16'h0, 16'h0, 16'h0, 16'h0, 16'h5a0f);
        $display("test unknown numbers done");
        st = 9'h000;
        do_reset(); // reset again in mid-run
        rd_all(16'h3211, 16'h0, 16'h0, 16'h0, 16'h2);
        settle();
        chk("circuit after reset", 16'h0, 16'(circ));
        ce = 1'b0;
        st = 9'h1ff;
        wr_param(num_route_one, 16'h0000);
        settle();
        chk("circuit frozen", 16'h0, 16'(circ));
        ce = 1'b1;
        settle();
        chk("circuit run", 16'h7, 16'(circ));
        rd_param(num_route_one, 16'h3211, "route one kept");
        @(posedge clock_in);
        #1 wr = 1'b1;
        rd = 1'b1;
        num = num_route_two;
        wdata = 16'h0200;
        @(posedge clock_in);
        #1 wr = 1'b0;
        rd = 1'b0;
        chk("old value", 16'h0000, rdata);
        rd_param(num_route_two, 16'h0200, "new value");
        st = 9'h040;
        settle();
        chk("brake on two", 16'h2, 16'(circ));
        $display("test enable and overlap done");
        test_done();
    end
endmodule
